//--- hdl/epdc_top.sv
// emitter pin drive control: registers, clock gating, pin muxes, bias enables
// assumes the modulation clock, channel select and light enable arrive from logic on clock
`timescale 1ns/1ps
module epdc_top
  import epdc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // host register port
  input wire epdc_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata_ff,
  // timing generator side
  input wire logic mod_clock,
  input wire logic [1:0] emitter_channel_select,
  input wire logic first_channel_light_enable,
  // emitter pins
  output logic emitter_pin_a,
  output logic emitter_pin_b,
  output logic emitter_pin_c,
  // light enable of the second channel
  output logic second_channel_light_enable,
  // analog driver controls
  output epdc_analog_t analog_ff
);
  logic rst_meta_ff;
  logic rst_sync_b_ff;
  logic driver_power_down_ff;
  logic bias_current_power_down_ff;
  logic [BIAS_CODE_W-1:0] bias_current_code_ff;
  logic bias_all_channels_enable_ff;
  logic second_follows_first_ff;
  logic inverted_mod_clock_gate_ff;
  logic true_mod_clock_gate_ff;
  logic [PIN_SRC_W-1:0] pin_source_ff [NUM_PINS];
  logic [DATA_W-1:0] drive_ctrl_view;
  logic [DATA_W-1:0] pin_src_view;
  logic [DATA_W-1:0] nxt_rdata;
  logic drive_ctrl_wr;
  logic pin_src_wr;
  logic mod_true;
  logic mod_inv;
  logic [NUM_PINS-1:0] pins;
  logic first_sel;
  epdc_analog_t nxt_analog;

  // write strobe for one register address
  function automatic logic reg_hit(input epdc_req_t req, input logic [ADDR_W-1:0] a);
    reg_hit = req.wr_en && (req.addr == a);
  endfunction

  // lowest bit of a pin's source field; pin order a, b, c is not bit order
  function automatic int pin_lsb(input int idx);
    case (idx)
      0: pin_lsb = PIN_A_LSB; // RL9
      1: pin_lsb = PIN_B_LSB; // RL11
      default: pin_lsb = PIN_C_LSB; // RL10
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d0,
    input logic [DATA_W-1:0] d1);
    if (a == ADDR_DRIVE_CTRL) begin
      read_mux = d0;
    end else if (a == ADDR_PIN_SRC) begin
      read_mux = d1;
    end else begin
      read_mux = '0;
    end
  endfunction

  // release reset through two flops so every flop behind them leaves reset on one edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_b_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_b_ff <= rst_meta_ff;
    end
  end

  assign drive_ctrl_wr = reg_hit(reg_req, ADDR_DRIVE_CTRL);
  assign pin_src_wr = reg_hit(reg_req, ADDR_PIN_SRC);

  // only named fields are stored; reserved bits have no flop at all
  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      driver_power_down_ff <= RST_DRIVE_CTRL[BIT_DRV_PDN];
    end else if (drive_ctrl_wr) begin
      driver_power_down_ff <= reg_req.wdata[BIT_DRV_PDN]; // RL2
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      bias_current_power_down_ff <= RST_DRIVE_CTRL[BIT_BIAS_PDN];
    end else if (drive_ctrl_wr) begin
      bias_current_power_down_ff <= reg_req.wdata[BIT_BIAS_PDN]; // RL3
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      bias_current_code_ff <= RST_DRIVE_CTRL[BIAS_CODE_LSB +: BIAS_CODE_W];
    end else if (drive_ctrl_wr) begin
      bias_current_code_ff <= reg_req.wdata[BIAS_CODE_LSB +: BIAS_CODE_W]; // RL4
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      bias_all_channels_enable_ff <= RST_DRIVE_CTRL[BIT_BIAS_ALL];
    end else if (drive_ctrl_wr) begin
      bias_all_channels_enable_ff <= reg_req.wdata[BIT_BIAS_ALL]; // RL5
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      second_follows_first_ff <= RST_DRIVE_CTRL[BIT_SECOND_FOLLOWS];
    end else if (drive_ctrl_wr) begin
      second_follows_first_ff <= reg_req.wdata[BIT_SECOND_FOLLOWS]; // RL6
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      inverted_mod_clock_gate_ff <= RST_DRIVE_CTRL[BIT_INV_GATE];
    end else if (drive_ctrl_wr) begin
      inverted_mod_clock_gate_ff <= reg_req.wdata[BIT_INV_GATE]; // RL7
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      true_mod_clock_gate_ff <= RST_DRIVE_CTRL[BIT_TRUE_GATE]; // RL8
    end else if (drive_ctrl_wr) begin
      true_mod_clock_gate_ff <= reg_req.wdata[BIT_TRUE_GATE]; // RL8
    end
  end

  // the invalid code is stored as written so software can read it back
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_src
      always_ff @(posedge clock or negedge rst_sync_b_ff) begin
        if (!rst_sync_b_ff) begin
          pin_source_ff[p] <= SRC_TRUE; // RL12
        end else if (pin_src_wr) begin
          pin_source_ff[p] <= reg_req.wdata[pin_lsb(p) +: PIN_SRC_W]; // RL13
        end
      end
    end
  endgenerate

  // reserved bits read back zero
  always_comb begin
    drive_ctrl_view = '0; // RL1
    drive_ctrl_view[BIT_DRV_PDN] = driver_power_down_ff;
    drive_ctrl_view[BIT_BIAS_PDN] = bias_current_power_down_ff;
    drive_ctrl_view[BIAS_CODE_LSB +: BIAS_CODE_W] = bias_current_code_ff;
    drive_ctrl_view[BIT_BIAS_ALL] = bias_all_channels_enable_ff;
    drive_ctrl_view[BIT_SECOND_FOLLOWS] = second_follows_first_ff;
    drive_ctrl_view[BIT_INV_GATE] = inverted_mod_clock_gate_ff;
    drive_ctrl_view[BIT_TRUE_GATE] = true_mod_clock_gate_ff;
  end

  always_comb begin
    pin_src_view = '0; // RL1
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_src_view[pin_lsb(i) +: PIN_SRC_W] = pin_source_ff[i]; // RL13
    end
  end

  // read data follows the address every cycle, one edge late
  assign nxt_rdata = read_mux(reg_req.addr, drive_ctrl_view, pin_src_view);

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // gated clocks are plain logic gates; the pins are reclocked below
  assign mod_true = mod_clock & true_mod_clock_gate_ff; // RL8
  assign mod_inv = ~mod_clock & inverted_mod_clock_gate_ff; // RL7

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      epdc_pin_sel u_sel (
        .clock(clock),
        .rst_sync_b(rst_sync_b_ff),
        .source(pin_source_ff[g]),
        .mod_true(mod_true),
        .mod_inv(mod_inv),
        .pin_ff(pins[g])
      );
    end
  endgenerate

  assign emitter_pin_a = pins[0];
  assign emitter_pin_b = pins[1];
  assign emitter_pin_c = pins[2];

  assign first_sel = (emitter_channel_select == CHAN_FIRST);
  // follow mode needed for static current drive
  assign second_channel_light_enable = second_follows_first_ff ? first_channel_light_enable
    : (emitter_channel_select == CHAN_SECOND); // RL6

  always_comb begin
    nxt_analog.driver_power_down = driver_power_down_ff; // RL2
    nxt_analog.bias_current_power_down = bias_current_power_down_ff; // RL3
    nxt_analog.bias_current_code = bias_current_code_ff; // RL4
    nxt_analog.bias_enable = '0;
    if (!bias_current_power_down_ff) begin
      if (first_sel && bias_all_channels_enable_ff) begin
        nxt_analog.bias_enable = '1; // RL5
      end else if (emitter_channel_select < 2'(NUM_PINS)) begin
        nxt_analog.bias_enable[emitter_channel_select] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      analog_ff <= '0;
    end else begin
      analog_ff <= nxt_analog;
    end
  end
endmodule

//--- hdl/epdc_pkg.sv
// emitter pin drive control: constants, field layout and carrier types
// assumes a host register port of 8-bit address and 24-bit data, one clock
// Operation
// RL1 - software writes zero to reserved fields of both registers and they read back as zero.
// RL2 - bit 19 of the drive control register powers down the illumination driver when set.
// RL3 - bit 12 removes the dc bias current through the transmit pins when set.
// RL4 - bits 11 to 8 form the bias current code, 0.5 mA per step, sent to the current source.
// RL5 - bit 4 with the first channel selected enables bias current on all three channels.
// RL6 - bit 3 makes the second channel follow the first channel's light enable.
// RL7 - bit 2 gates the inverted modulation clock, 1 enables it.
// RL8 - bit 0 gates the true modulation clock, 1 enables it, and it resets to one.
// RL9 - bits 5 to 4 pick the first pin source: 0 true clock, 2 inverted clock, 3 constant one.
// RL10 - bits 3 to 2 pick the third pin source with the same coding.
// RL11 - bits 1 to 0 pick the second pin source with the same coding.
// RL12 - the pin source register resets to all zeros.
// RL13 - the invalid code 1 drives the pin low and stays readable.
package epdc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;
  localparam logic [ADDR_W-1:0] ADDR_DRIVE_CTRL = 8'h79;
  localparam logic [ADDR_W-1:0] ADDR_PIN_SRC = 8'h7A;
  localparam logic [DATA_W-1:0] RST_DRIVE_CTRL = 24'h000001;
  localparam logic [DATA_W-1:0] RST_PIN_SRC = 24'h000000;
  // writable bits; everything else is reserved
  localparam logic [DATA_W-1:0] MASK_DRIVE_CTRL = 24'h081F1D;
  localparam logic [DATA_W-1:0] MASK_PIN_SRC = 24'h00003F;
  localparam int BIT_DRV_PDN = 19;
  localparam int BIT_BIAS_PDN = 12;
  localparam int BIAS_CODE_LSB = 8;
  localparam int BIAS_CODE_W = 4;
  localparam int BIT_BIAS_ALL = 4;
  localparam int BIT_SECOND_FOLLOWS = 3;
  localparam int BIT_INV_GATE = 2;
  localparam int BIT_TRUE_GATE = 0;
  localparam int PIN_A_LSB = 4;
  localparam int PIN_C_LSB = 2;
  localparam int PIN_B_LSB = 0;
  localparam int NUM_PINS = 3;
  localparam logic [1:0] SRC_TRUE = 2'h0;
  localparam logic [1:0] SRC_BAD = 2'h1;
  localparam logic [1:0] SRC_INV = 2'h2;
  localparam logic [1:0] SRC_ONE = 2'h3;
  localparam logic [1:0] CHAN_FIRST = 2'h0;
  localparam logic [1:0] CHAN_SECOND = 2'h1;
  localparam int PIN_SRC_W = 2;
  typedef struct packed {
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } epdc_req_t;
  typedef struct packed {
    logic driver_power_down;
    logic bias_current_power_down;
    logic [BIAS_CODE_W-1:0] bias_current_code;
    logic [NUM_PINS-1:0] bias_enable;
  } epdc_analog_t;
endpackage

//--- hdl/epdc_pin_sel.sv
// emitter pin drive control: one pin source selector
// assumes gated modulation clocks from the same clock domain
`timescale 1ns/1ps
module epdc_pin_sel
  import epdc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_sync_b,
  // source choice and clocks
  input wire logic [1:0] source,
  input wire logic mod_true,
  input wire logic mod_inv,
  // pin
  output logic pin_ff
);
  logic nxt_pin;
  always_comb begin
    case (source)
      SRC_TRUE: nxt_pin = mod_true;
      SRC_INV: nxt_pin = mod_inv;
      SRC_ONE: nxt_pin = 1'b1;
      SRC_BAD: nxt_pin = 1'b0; // RL13
      default: nxt_pin = 1'b0;
    endcase
  end
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end
endmodule

//--- tb/epdc_checker_properties.sv
// emitter pin drive control: port-level properties
// assumes no write before the internal reset release
`timescale 1ns/1ps
module epdc_checker_properties
  import epdc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // inputs
  input wire epdc_req_t reg_req,
  input wire logic [1:0] emitter_channel_select,
  input wire logic first_channel_light_enable,
  // outputs
  input wire logic [DATA_W-1:0] reg_rdata_ff,
  input wire logic emitter_pin_a,
  input wire logic emitter_pin_b,
  input wire logic second_channel_light_enable,
  input wire epdc_analog_t analog_ff
);
  logic [DATA_W-1:0] wd;
  assign wd = reg_req.wdata;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_w79; reg_req.wr_en && reg_req.addr == ADDR_DRIVE_CTRL; endsequence
  sequence s_w7a; reg_req.wr_en && reg_req.addr == ADDR_PIN_SRC; endsequence
  sequence s_w7a_rd; s_w7a ##1 !reg_req.wr_en && reg_req.addr == ADDR_PIN_SRC; endsequence
  a_pin_one: assert property (s_w7a ##0 wd[5:4] == SRC_ONE |-> ##2 emitter_pin_a)
    else $error("pin a not high");
  a_pin_bad_low: assert property (s_w7a ##0 wd[1:0] == SRC_BAD |-> ##2 !emitter_pin_b)
    else $error("pin b not low");
  a_src_readback: assert property (s_w7a_rd |=> reg_rdata_ff == ($past(wd, 2) & MASK_PIN_SRC))
    else $error("source readback wrong");
  a_reserved_zero: assert property ($past(reg_req.addr) == ADDR_DRIVE_CTRL |-> !(reg_rdata_ff & ~MASK_DRIVE_CTRL))
    else $error("reserved bits set");
  a_driver_pdn: assert property (s_w79 |-> ##2 analog_ff.driver_power_down == $past(wd[19], 2))
    else $error("driver power down wrong");
  a_bias_code: assert property (s_w79 |-> ##2 analog_ff.bias_current_code == 4'($past(wd, 2) >> 8))
    else $error("bias code wrong");
  a_bias_all_on: assert property (s_w79 ##0 wd[4] && !wd[12] ##1 emitter_channel_select == CHAN_FIRST
    |=> analog_ff.bias_enable == 3'h7) else $error("bias not on all");
  a_second_follows: assert property (s_w79 ##0 wd[3] |=> second_channel_light_enable == first_channel_light_enable)
    else $error("second channel not following");
endmodule
bind epdc_top epdc_checker_properties epdc_checker_properties_i (.*);

//--- tb/epdc_emitters.sv
// emitter load model: counts cycles with any emitter lit
// assumes pins settle on the system clock
`timescale 1ns/1ps
module epdc_emitters (
  // clock
  input wire logic clock,
  // emitter pins
  input wire logic [2:0] pins,
  output int lit
);
  initial lit = 0;
  always @(posedge clock) if (|pins) lit <= lit + 1;
endmodule

//--- tb/epdc_top_tb.sv
// emitter pin drive control bench: random writes against a reference model
// assumes the design, checker and emitter model compiled first
`timescale 1ns/1ps
module epdc_top_tb;
  import epdc_pkg::*;
  logic clock = 0, rst_b = 0, mod_clock = 0, first_channel_light_enable = 0;
  logic emitter_pin_a, emitter_pin_b, emitter_pin_c, second_channel_light_enable;
  logic [1:0] emitter_channel_select = 0;
  logic [DATA_W-1:0] reg_rdata_ff, r79 = RST_DRIVE_CTRL, r7a = RST_PIN_SRC;
  logic [31:0] seed = 32'h6878, w;
  epdc_req_t reg_req = '0;
  epdc_analog_t analog_ff;
  logic [ADDR_W-1:0] wa;
  logic [DATA_W-1:0] wv;
  int bad_count = 0, check_count = 0, lit, lit_mark;
  epdc_top epdc_top_i (.*);
  epdc_emitters epdc_emitters_i (.clock, .pins({emitter_pin_c, emitter_pin_b, emitter_pin_a}), .lit);
  initial forever #4 clock = ~clock;
  initial begin
    #100us;
    bad_count++;
    tally_and_finish();
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // pins follow the clock level seen at the last edge
  function logic pin(logic [1:0] s);
    return s == SRC_TRUE ? mod_clock & r79[0] : s == SRC_INV ? !mod_clock & r79[2] : s == SRC_ONE;
  endfunction
  function logic [2:0] bias();
    if (r79[12] || emitter_channel_select == 2'h3) return 3'h0;
    if (emitter_channel_select == 2'h0) return r79[4] ? 3'h7 : 3'h1;
    return emitter_channel_select == 2'h1 ? 3'h2 : 3'h4;
  endfunction
  task chk(input logic [DATA_W-1:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(negedge clock) reg_req.addr = a;
    @(negedge clock) chk(reg_rdata_ff, e, "rdata");
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst_b = 1;
    repeat (3) @(negedge clock);
    rd(ADDR_DRIVE_CTRL, 24'h000001);
    rd(ADDR_PIN_SRC, 24'h000000);
    for (int i = 0; i < 300; i++) begin
      w = rnd();
      @(negedge clock) {mod_clock, first_channel_light_enable, emitter_channel_select} = w[3:0];
      wa = w[8] ? ADDR_PIN_SRC : w[9] ? ADDR_DRIVE_CTRL : w[31:24];
      // software keeps reserved fields at zero
      wv = DATA_W'(rnd()) & (wa == ADDR_DRIVE_CTRL ? MASK_DRIVE_CTRL : MASK_PIN_SRC);
      reg_req = '{1'b1, wa, wv};
      if (wa == ADDR_DRIVE_CTRL) r79 = wv;
      if (wa == ADDR_PIN_SRC) r7a = wv;
      @(negedge clock) reg_req.wr_en = 0;
      @(negedge clock);
      chk(emitter_pin_a, pin(r7a[5:4]), "pin_a");
      chk(emitter_pin_b, pin(r7a[1:0]), "pin_b");
      chk(emitter_pin_c, pin(r7a[3:2]), "pin_c");
      chk(second_channel_light_enable, r79[3] ? first_channel_light_enable : emitter_channel_select == 2'h1, "b_en");
      chk(analog_ff, {r79[19], r79[12], r79[11:8], bias()}, "analog");
      lit_mark = lit;
      rd(ADDR_DRIVE_CTRL, r79);
      rd(ADDR_PIN_SRC, r7a);
      // four edges pass during the two reads with the pins unchanged
      chk(lit - lit_mark, |{pin(r7a[5:4]), pin(r7a[1:0]), pin(r7a[3:2])} ? 4 : 0, "lit");
    end
    tally_and_finish();
  end
endmodule
